// *** inc/ulm_pkg.sv ***
package ulm_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] ULM_OFS_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] ULM_OFS_LINE_STATUS   = 3'h5;
	localparam logic [2:0] ULM_OFS_MODEM_STATUS  = 3'h6;
	localparam logic [2:0] ULM_OFS_SCRATCH       = 3'h7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ULM_MCR_RST     = 8'h00;
	localparam logic [7:0] ULM_SCRATCH_RST = 8'hff;
	localparam logic [7:0] ULM_TLR_RST     = 8'h00;
	localparam logic [7:0] ULM_TCR_RST     = 8'h00;
	localparam logic [7:0] ULM_ZERO_BYTE   = 8'h00;

	// ----------------------------------------------------------------
	// Modem control fields
	// ----------------------------------------------------------------
	localparam int ULM_MCR_DTR     = 0;
	localparam int ULM_MCR_RTS     = 1;
	localparam int ULM_MCR_SEL     = 2;
	localparam int ULM_MCR_OUT2    = 3;
	localparam int ULM_MCR_LOOP    = 4;
	localparam int ULM_MCR_XON_ANY = 5;
	localparam int ULM_MCR_PRESC   = 7;
	localparam logic [7:0] ULM_MCR_WMASK_PLAIN = 8'h1f;
	localparam logic [7:0] ULM_MCR_WMASK_ENH   = 8'ha0;

	// ----------------------------------------------------------------
	// Line status fields
	// ----------------------------------------------------------------
	localparam int ULM_LSR_DATA   = 0;
	localparam int ULM_LSR_OVR    = 1;
	localparam int ULM_LSR_PAR    = 2;
	localparam int ULM_LSR_FRM    = 3;
	localparam int ULM_LSR_BRK    = 4;
	localparam int ULM_LSR_THE    = 5;
	localparam int ULM_LSR_TEMT   = 6;
	localparam int ULM_LSR_FIFOER = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [1:0] ULM_PRESC_LAST = 2'h3;
	localparam logic [1:0] ULM_PRESC_ONE  = 2'h1;
	localparam logic [1:0] ULM_PRESC_RST  = 2'h0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic char_done;
		logic fifo_full;
		logic data_avail;
		logic top_parity_err;
		logic top_frame_err;
		logic top_break;
		logic fifo_err_any;
		logic char_is_flow;
	} ulm_rx_s;

	typedef struct packed {
		logic cd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} ulm_modem_s;

	typedef struct packed {
		logic [5:0] resume;
		logic [5:0] halt;
	} ulm_levels_s;

endpackage

// *** design/ulm_modem_delta.sv ***
`timescale 1ns/1ps
module ulm_modem_delta (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Status levels {cd, ri, dsr, cts} and clear strobe
	input  wire logic [3:0] level,
	input  wire logic       clear,
	// Sticky delta flags
	output logic      [3:0] delta
);
	import ulm_pkg::*;

	logic [3:0] prev;
	logic       primed;
	logic [3:0] set_now;

	// ----------------------------------------------------------------
	// Change detection
	// ----------------------------------------------------------------
	always_comb begin
		set_now = 4'h0;
		if (primed) begin
			set_now = level ^ prev;
			set_now[2] = prev[2] & ~level[2];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev   <= 4'h0;
			primed <= 1'b0;
		end else begin
			prev   <= level;
			primed <= 1'b1;
		end
	end

	// Set wins over a read clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			delta <= 4'h0;
		end else begin
			delta <= (clear ? 4'h0 : delta) | set_now;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_delta_change;
		@(posedge clk) disable iff (!rstn)
		(primed && (level[0] != prev[0])) |=> delta[0];
	endproperty
	a_delta_change: assert property (p_delta_change) else $error("cts delta missed");

	property p_ri_trail;
		@(posedge clk) disable iff (!rstn)
		(primed && prev[2] && !level[2] && !delta[2]) |=> delta[2];
	endproperty
	a_ri_trail: assert property (p_ri_trail) else $error("ri trailing edge missed");

	property p_ri_lead;
		@(posedge clk) disable iff (!rstn)
		(!prev[2] && level[2] && !delta[2]) |=> !delta[2];
	endproperty
	a_ri_lead: assert property (p_ri_lead) else $error("ri delta set on wrong edge");

	property p_clear;
		@(posedge clk) disable iff (!rstn)
		(clear && primed && (level == prev)) |=> (delta == 4'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("delta not cleared on read");

endmodule

// *** design/ulm_status_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Offset 7 reads scratch, or trigger level when enhanced enable and select are both set.
// - Offset 6 reads modem status, or halt/resume levels when both bits are set.
// - Control bit 3 low: interrupt outputs floating, spare output 2 high; high: reversed.
// - Control bit 4 enables internal loopback; cleared at reset.
// - Control bit 5 lets any received character resume a halted transmitter.
// - Control bit 7 divides the baud clock by four; writable only with enhanced enable.
// - Status bit 0 is set while received data waits.
// - Overrun sets when a character completes into a full receive FIFO.
// - Parity and framing flags follow the character at the read position.
// - Break flag follows the break tag of the character at the read position.
// - Holding-empty flag follows the holding register or transmit FIFO being empty.
// - Transmitter-empty flag needs both holding and shift stages empty.
// - FIFO error flag stays set while any errored byte remains in the FIFO.
// - Delta flags for cts, dsr, cd set on any change; raise modem interrupt.
// - Ring delta sets only at the end of ringing; raises modem interrupt.
// - With auto cts, a high cts pin pauses transmission after the current character.
// - Outside loopback, status bits 4 to 7 show the inverted modem input pins.
// - In loopback, status bits 4 to 7 mirror control bits 1, 0, 2, 3.
// - Scratch is a plain 8-bit store resetting to all ones.
// - Halt/resume levels replace modem status only under enhanced enable and select.
// - Halt level is low nibble times four, resume level high nibble times four.
module ulm_status_ctrl (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// Register port
	input  wire logic [2:0]           reg_addr,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	// Settings held elsewhere
	input  wire logic                 enh_enable,
	input  wire logic                 modem_int_enable,
	input  wire logic                 auto_cts_enable,
	input  wire logic                 sw_flow_active,
	// Receiver and transmitter status
	input  wire ulm_pkg::ulm_rx_s     rx,
	input  wire logic                 tx_hold_empty,
	input  wire logic                 tx_shift_empty,
	input  wire logic                 tx_halted,
	// Modem input pins
	input  wire ulm_pkg::ulm_modem_s  modem_in,
	// Modem and spare outputs
	output logic                      dtr_n,
	output logic                      rts_n,
	output logic                      spare_output_2_n,
	output logic                      irq_out_oe,
	output logic                      modem_irq,
	// Controls to neighbouring logic
	output logic                      loopback,
	output logic                      baud_clk_en,
	output logic                      xon_any_resume,
	output logic                      rx_store,
	output logic                      tx_pause,
	output ulm_pkg::ulm_levels_s      levels,
	output logic      [7:0]           trig_level
);
	import ulm_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic stb, input logic [2:0] a, input logic [2:0] ofs);
		return stb && (a == ofs);
	endfunction

	function automatic logic alt_page(input logic enh, input logic sel);
		return enh && sel;
	endfunction

	function automatic logic [5:0] lvl_x4(input logic [3:0] n);
		return {n, 2'h0};
	endfunction

	logic [7:0] modem_control;
	logic [7:0] scratch_store;
	logic [7:0] fifo_trigger_level;
	logic [7:0] flow_halt_resume_levels;
	logic [7:0] line_status;
	logic [7:0] modem_status;
	logic [7:0] next_modem_control;
	logic [7:0] next_rdata;
	logic [7:0] mcr_wmask;
	logic [3:0] modem_level;
	logic [3:0] modem_delta;
	logic [1:0] presc_cnt;
	logic       alt;
	logic       overrun;
	logic       msr_rd;
	logic       lsr_rd;

	// ----------------------------------------------------------------
	// Page select at offsets 6 and 7
	// ----------------------------------------------------------------
	assign alt    = alt_page(enh_enable, modem_control[ULM_MCR_SEL]);
	assign msr_rd = hit(reg_rd, reg_addr, ULM_OFS_MODEM_STATUS) && !alt;
	assign lsr_rd = hit(reg_rd, reg_addr, ULM_OFS_LINE_STATUS);

	// ----------------------------------------------------------------
	// Modem control
	// ----------------------------------------------------------------
	always_comb begin
		mcr_wmask = ULM_MCR_WMASK_PLAIN;
		if (enh_enable) begin
			mcr_wmask = ULM_MCR_WMASK_PLAIN | ULM_MCR_WMASK_ENH;
		end
		next_modem_control = modem_control;
		if (hit(reg_wr, reg_addr, ULM_OFS_MODEM_CONTROL)) begin
			next_modem_control = (modem_control & ~mcr_wmask) | (reg_wdata & mcr_wmask);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modem_control <= ULM_MCR_RST;
		end else begin
			modem_control <= next_modem_control;
		end
	end

	// ----------------------------------------------------------------
	// Scratch, trigger level and halt/resume levels
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scratch_store      <= ULM_SCRATCH_RST;
			fifo_trigger_level <= ULM_TLR_RST;
		end else if (hit(reg_wr, reg_addr, ULM_OFS_SCRATCH)) begin
			if (alt) begin
				fifo_trigger_level <= reg_wdata;
			end else begin
				scratch_store <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flow_halt_resume_levels <= ULM_TCR_RST;
		end else if (hit(reg_wr, reg_addr, ULM_OFS_MODEM_STATUS) && alt) begin
			flow_halt_resume_levels <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Line status
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			overrun <= 1'b0;
		end else if (rx.char_done && rx.fifo_full) begin
			overrun <= 1'b1;
		end else if (lsr_rd) begin
			overrun <= 1'b0;
		end
	end

	always_comb begin
		line_status                 = ULM_ZERO_BYTE;
		line_status[ULM_LSR_DATA]   = rx.data_avail;
		line_status[ULM_LSR_OVR]    = overrun;
		line_status[ULM_LSR_PAR]    = rx.top_parity_err;
		line_status[ULM_LSR_FRM]    = rx.top_frame_err;
		line_status[ULM_LSR_BRK]    = rx.top_break;
		line_status[ULM_LSR_THE]    = tx_hold_empty;
		line_status[ULM_LSR_TEMT]   = tx_hold_empty && tx_shift_empty;
		line_status[ULM_LSR_FIFOER] = rx.fifo_err_any;
	end

	// ----------------------------------------------------------------
	// Modem status
	// ----------------------------------------------------------------
	always_comb begin
		if (modem_control[ULM_MCR_LOOP]) begin
			modem_level = {modem_control[ULM_MCR_OUT2], modem_control[ULM_MCR_SEL],
				modem_control[ULM_MCR_DTR], modem_control[ULM_MCR_RTS]};
		end else begin
			modem_level = ~modem_in;
		end
		modem_status = {modem_level, modem_delta};
	end

	ulm_modem_delta u_delta (
		.clk   (clk),
		.rstn  (rstn),
		.level (modem_level),
		.clear (msr_rd),
		.delta (modem_delta)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		case (reg_addr)
			ULM_OFS_MODEM_CONTROL: begin
				next_rdata = modem_control;
			end
			ULM_OFS_LINE_STATUS: begin
				next_rdata = line_status;
			end
			ULM_OFS_MODEM_STATUS: begin
				next_rdata = alt ? flow_halt_resume_levels : modem_status;
			end
			ULM_OFS_SCRATCH: begin
				next_rdata = alt ? fifo_trigger_level : scratch_store;
			end
			default: begin
				next_rdata = ULM_ZERO_BYTE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= ULM_ZERO_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Pin and control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dtr_n            <= 1'b1;
			rts_n            <= 1'b1;
			spare_output_2_n <= 1'b1;
			irq_out_oe       <= 1'b0;
			loopback         <= 1'b0;
		end else begin
			dtr_n            <= next_modem_control[ULM_MCR_LOOP] || !next_modem_control[ULM_MCR_DTR];
			rts_n            <= next_modem_control[ULM_MCR_LOOP] || !next_modem_control[ULM_MCR_RTS];
			spare_output_2_n <= !next_modem_control[ULM_MCR_OUT2];
			irq_out_oe       <= next_modem_control[ULM_MCR_OUT2];
			loopback         <= next_modem_control[ULM_MCR_LOOP];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modem_irq <= 1'b0;
		end else begin
			modem_irq <= modem_int_enable && (|modem_delta);
		end
	end

	// Baud clock prescaler
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			presc_cnt   <= ULM_PRESC_RST;
			baud_clk_en <= 1'b0;
		end else if (!modem_control[ULM_MCR_PRESC]) begin
			presc_cnt   <= ULM_PRESC_RST;
			baud_clk_en <= 1'b1;
		end else begin
			presc_cnt   <= presc_cnt + ULM_PRESC_ONE;
			baud_clk_en <= (presc_cnt == ULM_PRESC_LAST);
		end
	end

	// Receive side and auto cts flow decisions
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			xon_any_resume <= 1'b0;
			rx_store       <= 1'b0;
			tx_pause       <= 1'b0;
		end else begin
			xon_any_resume <= modem_control[ULM_MCR_XON_ANY] && rx.char_done && tx_halted;
			rx_store       <= rx.char_done && !rx.fifo_full &&
				!(rx.char_is_flow && sw_flow_active);
			tx_pause       <= auto_cts_enable && modem_in.cts_n;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			levels     <= '0;
			trig_level <= ULM_TLR_RST;
		end else begin
			levels.halt   <= lvl_x4(flow_halt_resume_levels[3:0]);
			levels.resume <= lvl_x4(flow_halt_resume_levels[7:4]);
			trig_level    <= fifo_trigger_level;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_spr_read;
		@(posedge clk) disable iff (!rstn)
		(hit(reg_rd, reg_addr, ULM_OFS_SCRATCH) && !alt) |=> (reg_rdata == $past(scratch_store));
	endproperty
	a_spr_read: assert property (p_spr_read) else $error("scratch not read at offset 7");

	property p_tlr_read;
		@(posedge clk) disable iff (!rstn)
		(hit(reg_rd, reg_addr, ULM_OFS_SCRATCH) && alt) |=> (reg_rdata == $past(fifo_trigger_level));
	endproperty
	a_tlr_read: assert property (p_tlr_read) else $error("trigger level not read at offset 7");

	property p_tcr_read;
		@(posedge clk) disable iff (!rstn)
		(hit(reg_rd, reg_addr, ULM_OFS_MODEM_STATUS) && alt) |=> (reg_rdata == $past(flow_halt_resume_levels));
	endproperty
	a_tcr_read: assert property (p_tcr_read) else $error("levels not read at offset 6");

	property p_out2;
		@(posedge clk) disable iff (!rstn)
		(spare_output_2_n != irq_out_oe) && (irq_out_oe == modem_control[ULM_MCR_OUT2]);
	endproperty
	a_out2: assert property (p_out2) else $error("spare output 2 and interrupt enable disagree");

	property p_presc_lock;
		@(posedge clk) disable iff (!rstn)
		(hit(reg_wr, reg_addr, ULM_OFS_MODEM_CONTROL) && !enh_enable) |=>
			(modem_control[ULM_MCR_PRESC] == $past(modem_control[ULM_MCR_PRESC]));
	endproperty
	a_presc_lock: assert property (p_presc_lock) else $error("prescaler bit written without enable");

	property p_presc_div;
		@(posedge clk) disable iff (!rstn)
		(modem_control[ULM_MCR_PRESC] && baud_clk_en) ##1 modem_control[ULM_MCR_PRESC] |-> !baud_clk_en;
	endproperty
	a_presc_div: assert property (p_presc_div) else $error("divided baud enable back to back");

	property p_data_ready;
		@(posedge clk) disable iff (!rstn)
		lsr_rd |=> (reg_rdata[ULM_LSR_DATA] == $past(rx.data_avail));
	endproperty
	a_data_ready: assert property (p_data_ready) else $error("data ready wrong");

	property p_overrun;
		@(posedge clk) disable iff (!rstn)
		(rx.char_done && rx.fifo_full) |=> overrun ##0 !rx_store;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed or byte stored");

	property p_temt;
		@(posedge clk) disable iff (!rstn)
		(lsr_rd ##1 reg_rdata[ULM_LSR_TEMT]) |-> $past(tx_hold_empty && tx_shift_empty);
	endproperty
	a_temt: assert property (p_temt) else $error("transmitter empty while busy");

	property p_cts_pause;
		@(posedge clk) disable iff (!rstn)
		(auto_cts_enable && modem_in.cts_n) |=> tx_pause;
	endproperty
	a_cts_pause: assert property (p_cts_pause) else $error("auto cts did not pause");

	property p_loop_mirror;
		@(posedge clk) disable iff (!rstn)
		(msr_rd && modem_control[ULM_MCR_LOOP]) |=> (reg_rdata[4] == $past(modem_control[ULM_MCR_RTS]));
	endproperty
	a_loop_mirror: assert property (p_loop_mirror) else $error("loopback cts mirror wrong");

	property p_spr_write;
		@(posedge clk) disable iff (!rstn)
		(hit(reg_wr, reg_addr, ULM_OFS_SCRATCH) && !alt) |=> (scratch_store == $past(reg_wdata));
	endproperty
	a_spr_write: assert property (p_spr_write) else $error("scratch write lost");

	property p_levels;
		@(posedge clk) disable iff (!rstn)
		1'b1 |=> (levels.halt == {$past(flow_halt_resume_levels[3:0]), 2'h0});
	endproperty
	a_levels: assert property (p_levels) else $error("halt level scaling wrong");

endmodule

// *** tb/ulm_far_model.sv ***
`timescale 1ns/1ps
module ulm_far_model (
	// Clock
	input  wire logic           clk,
	// Modem pins toward the device
	output ulm_pkg::ulm_modem_s modem_in
);
	import ulm_pkg::*;

	// Pins rest inactive high
	initial modem_in = '1;

	// New pin levels just after an edge; a high cts pauses the device when auto cts is enabled
	task automatic set_pins(input ulm_modem_s val);
		@(posedge clk);
		#1;
		modem_in = val;
	endtask
endmodule

// *** tb/uart_line_modem_status_ctrl_test.sv ***
`timescale 1ns/1ps
module uart_line_modem_status_ctrl_test;
	import ulm_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk, rstn, reg_wr, reg_rd, enh, mie, acts, swf, the, tse, thalt;
	logic        dtr_n, rts_n, op2_n, oe, mirq, lb, bce, xar, rx_st, txp;
	logic [2:0]  addr;
	logic [7:0]  wd, rd, v, d, trig;
	logic [3:0]  dl, c;
	ulm_rx_s     rx;
	ulm_modem_s  mi, m, p;
	ulm_levels_s lv;
	int          n;
	int          miscompares = 0;
	int          n_checks = 0;

	ulm_status_ctrl i_dut (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(wd), .reg_rdata(rd), .enh_enable(enh), .modem_int_enable(mie), .auto_cts_enable(acts),
		.sw_flow_active(swf), .rx(rx), .tx_hold_empty(the), .tx_shift_empty(tse), .tx_halted(thalt),
		.modem_in(mi), .dtr_n(dtr_n), .rts_n(rts_n), .spare_output_2_n(op2_n), .irq_out_oe(oe),
		.modem_irq(mirq), .loopback(lb), .baud_clk_en(bce), .xon_any_resume(xar), .rx_store(rx_st),
		.tx_pause(txp), .levels(lv), .trig_level(trig));
	ulm_far_model i_far (.clk(clk), .modem_in(mi));

	// ----------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] dat);
		addr = a;
		wd = dat;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
	endtask

	task automatic rdr(input logic [2:0] a, output logic [7:0] dat);
		addr = a;
		reg_rd = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		tick(1);
		dat = rd;
	endtask

	task automatic baud(output int k);
		k = 0;
		repeat (8) begin
			k += (bce === 1'b1) ? 1 : 0;
			tick(1);
		end
	endtask

	function automatic logic [7:0] lsr_exp(input ulm_rx_s r, input logic he, input logic se, input logic ov);
		return {r.fifo_err_any, he & se, he, r.top_break, r.top_frame_err, r.top_parity_err, ov, r.data_avail};
	endfunction

	function automatic logic [3:0] delta_exp(input ulm_modem_s a, input ulm_modem_s b);
		return {a.cd_n ^ b.cd_n, ~a.ri_n & b.ri_n, a.dsr_n ^ b.dsr_n, a.cts_n ^ b.cts_n};
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		{rstn, reg_wr, reg_rd, enh, mie, acts, swf, thalt, addr, wd} = '0;
		rx = '0;
		{the, tse} = 2'b11;
		v = 8'($urandom(29101));
		repeat (6) @(posedge clk);
		#1;
		rstn = 1'b1;
		tick(1);
		rdr(ULM_OFS_SCRATCH, v);
		chk("scratch reset", 8'hff, v);
		rdr(ULM_OFS_MODEM_CONTROL, v);
		chk("control reset", 8'h00, v);
		chk("loopback reset", 8'h00, {7'h00, lb});
		rdr(3'h2, v);
		chk("unmapped", 8'h00, v);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			wr(ULM_OFS_SCRATCH, d);
			rdr(ULM_OFS_SCRATCH, v);
			chk("scratch", d, v);
		end
		enh = 1'b1;
		wr(ULM_OFS_MODEM_CONTROL, 8'h04);
		wr(ULM_OFS_SCRATCH, ~d);
		rdr(ULM_OFS_SCRATCH, v);
		chk("trigger level", ~d, v);
		chk("trigger out", ~d, trig);
		wr(ULM_OFS_MODEM_STATUS, {4'hf, 4'($urandom)});
		rdr(ULM_OFS_MODEM_STATUS, v);
		chk("levels reg", {4'hf, wd[3:0]}, v);
		chk("halt", {wd[3:0], 2'h0}, {2'h0, lv.halt});
		chk("resume", 8'h3c, {2'h0, lv.resume});
		enh = 1'b0;
		rdr(ULM_OFS_SCRATCH, v);
		chk("scratch back", d, v);
		$display("test pages done");
		wr(ULM_OFS_MODEM_CONTROL, 8'hff);
		rdr(ULM_OFS_MODEM_CONTROL, v);
		chk("control plain", 8'h1f, v);
		chk("irq drive", 8'h01, {7'h00, oe});
		chk("spare out", 8'h00, {7'h00, op2_n});
		chk("loopback", 8'h01, {7'h00, lb});
		chk("dtr rts loop", 8'h03, {6'h00, dtr_n, rts_n});
		enh = 1'b1;
		wr(ULM_OFS_MODEM_CONTROL, 8'hff);
		rdr(ULM_OFS_MODEM_CONTROL, v);
		chk("control enh", 8'hbf, v);
		baud(n);
		chk("baud div4", 8'h02, 8'(n));
		wr(ULM_OFS_MODEM_CONTROL, 8'h00);
		chk("irq float", 8'h01, {oe, op2_n});
		tick(1);
		baud(n);
		chk("baud div1", 8'h08, 8'(n));
		$display("test control done");
		for (int i = 0; i < 6; i++) begin
			rx = ulm_rx_s'(8'($urandom));
			rx.char_done = 1'b0;
			{the, tse} = 2'($urandom);
			tick(1);
			rdr(ULM_OFS_LINE_STATUS, v);
			chk("line status", lsr_exp(rx, the, tse, 1'b0), v);
		end
		wr(ULM_OFS_MODEM_CONTROL, 8'h20);
		swf = 1'b1;
		for (int k = 0; k < 4; k++) begin
			rx = '0;
			{rx.fifo_full, rx.char_is_flow} = 2'(k);
			rx.char_done = 1'b1;
			thalt = (k != 3);
			tick(1);
			rx.char_done = 1'b0;
			chk("store", {7'h00, k == 0}, {7'h00, rx_st});
			chk("xon any", {7'h00, k != 3}, {7'h00, xar});
		end
		rdr(ULM_OFS_LINE_STATUS, v);
		chk("overrun", lsr_exp(rx, the, tse, 1'b1), v);
		rdr(ULM_OFS_LINE_STATUS, v);
		chk("overrun read", lsr_exp(rx, the, tse, 1'b0), v);
		$display("test line status done");
		{enh, mie} = 2'h1;
		wr(ULM_OFS_MODEM_CONTROL, 8'h00);
		tick(2);
		rdr(ULM_OFS_MODEM_STATUS, v);
		p = mi;
		for (int i = 0; i < 8; i++) begin
			m = ulm_modem_s'(4'($urandom));
			i_far.set_pins(m);
			tick(3);
			dl = delta_exp(p, m);
			chk("modem irq", {7'h00, |dl}, {7'h00, mirq});
			rdr(ULM_OFS_MODEM_STATUS, v);
			chk("modem status", {~m, dl}, v);
			rdr(ULM_OFS_MODEM_STATUS, v);
			chk("delta clear", {~m, 4'h0}, v);
			p = m;
		end
		for (int i = 0; i < 3; i++) begin
			c = 4'($urandom);
			wr(ULM_OFS_MODEM_CONTROL, {4'h1, c});
			rdr(ULM_OFS_MODEM_STATUS, v);
			chk("loop status", {4'h0, c[3], c[2], c[0], c[1]}, {4'h0, v[7:4]});
		end
		wr(ULM_OFS_MODEM_CONTROL, 8'h03);
		chk("dtr rts drive", 8'h00, {6'h00, dtr_n, rts_n});
		$display("test modem status done");
		acts = 1'b1;
		i_far.set_pins(4'he);
		tick(2);
		chk("pause off", 8'h00, {7'h00, txp});
		i_far.set_pins(4'hf);
		tick(2);
		chk("pause on", 8'h01, {7'h00, txp});
		acts = 1'b0;
		tick(2);
		chk("pause disabled", 8'h00, {7'h00, txp});
		$display("test flow pause done");
		conclude();
	end
endmodule
